// >>> hdl/sync_serial_defs.svh
// register offsets, field positions and reset values of the serial port
`ifndef SYNC_SERIAL_DEFS_SVH
`define SYNC_SERIAL_DEFS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_RX_STAT 8'h00
`define OFS_RX_DATA 8'h04
`define OFS_TX_STAT 8'h08
`define OFS_BAUD_CTL 8'h0C
`define OFS_DIV_HI 8'h10
`define OFS_DIV_LO 8'h14
`define OFS_TX_DATA 8'h18
`define OFS_IRQ_FLAGS 8'h1C
`define OFS_IRQ_EN 8'h20
`define OFS_IRQ_PRIO 8'h24
`define OFS_CORE_CTL 8'h28
// ----------------------------------------
// field positions
// ----------------------------------------
`define B_PORT_EN 7
`define B_RX9_EN 6
`define B_SINGLE_RECEIVE_ENABLE 5
`define B_CONTINUOUS_RECEIVE_ENABLE 4
`define B_OVERRUN 1
`define B_RX9_VAL 0
`define B_CLOCK_SOURCE_MASTER 7
`define B_TX9_EN 6
`define B_TRANSMIT_ENABLE 5
`define B_SYNC 4
`define B_TRMT 1
`define B_TX9_VAL 0
`define B_WIDE_DIV 3
`define B_RXF 5
`define B_TXF 4
`define B_GIE 7
`define B_PERIPHERAL_IRQ_ENABLE 6
// ----------------------------------------
// reset values and character lengths
// ----------------------------------------
`define RST_BYTE 8'h00
`define LEN_NARROW 4'h8
`define LEN_WIDE 4'h9
`endif

// >>> hdl/sync_serial_pkg.sv
// types shared by the synchronous serial port
package sync_serial_pkg;
   // operating direction of the serial unit
   typedef enum logic [1:0]
   {
      MODE_OFF = 2'b00,
      MODE_TX = 2'b01,
      MODE_RX = 2'b10
   } link_mode_e;
   typedef logic [8:0] char_t; // one character, ninth bit on top
endpackage : sync_serial_pkg

// >>> hdl/sync_serial_port.sv
// synchronous serial port: master receive, slave transmit and receive
// What this block does
// - ninth-bit enable gives nine-bit characters
// - receive enables start master clock generation
// - receive flag set after full character
// - interrupt when receive flag and enable
// - data read returns oldest character low byte
// - overrun cleared by continuous enable or port
// - clock-source bit low selects slave clocking
// - slave transmits unless a receive enable set
// - unit works only with port enable
// - first written character starts shifting immediately
// - second character held, transmit flag clear
// - held character moves, then transmit flag sets
// - transmit flag with enables wakes core
// - slave receive always continuous, single enable alone also receives
// - slave keeps receiving while core sleeps
// - completed character wakes core, vector gated
// - drive on leading edge, sample on trailing
// - two-deep buffer, third character sets overrun
// - master single receive runs one character, clears
// - new character waits for previous last bit
`timescale 1ns/100ps
`include "sync_serial_defs.svh"
module sync_serial_port
   import sync_serial_pkg::*;
(
   input wire logic clk_sys, // system clock
   input wire logic rst, // synchronous reset, high
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb write
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error, unmapped
   input wire logic dataIn, // data pin input
   output logic dataOut, // data pin output
   output logic dataOe, // data pin drive enable
   input wire logic clkPinIn, // link clock pin input
   output logic clkPinOut, // link clock pin output
   output logic clkPinOe, // link clock pin drive enable
   output logic wakeReq, // wake request to the core
   output logic irqVector // vectored interrupt request
);

   // ----------------------------------------
   // register storage
   // ----------------------------------------
   logic [7:0] rxCtl_reg; // receive control byte
   logic [7:0] txCtl_reg; // transmit control byte
   logic [7:0] baudCtl_reg; // baud options
   logic [7:0] divHi_reg; // divisor high byte
   logic [7:0] divLo_reg; // divisor low byte
   logic [7:0] irqEn_reg; // flag enables
   logic [7:0] irqPrio_reg; // priorities, stored only
   logic [7:0] coreCtl_reg; // global and peripheral enable
   logic overrun_reg; // receive overrun
   logic [31:0] prdata_reg; // captured read data
   logic pslverr_reg; // captured decode error
   logic wakeReq_reg; // registered wake
   logic irqVector_reg; // registered vector request

   // ----------------------------------------
   // decoded control bits
   // ----------------------------------------
   logic portEn; // unit enable
   logic unitRst; // reset or unit disabled
   logic masterSel; // generate clock ourselves
   logic srenBit; // single receive
   logic crenBit; // continuous receive
   logic rx9En; // nine-bit receive
   logic tx9En; // nine-bit transmit
   link_mode_e linkMode; // current direction

   assign portEn = rxCtl_reg[`B_PORT_EN];
   assign unitRst = rst | ~portEn;
   assign masterSel = txCtl_reg[`B_CLOCK_SOURCE_MASTER];
   assign srenBit = rxCtl_reg[`B_SINGLE_RECEIVE_ENABLE];
   assign crenBit = rxCtl_reg[`B_CONTINUOUS_RECEIVE_ENABLE];
   assign rx9En = rxCtl_reg[`B_RX9_EN];
   assign tx9En = txCtl_reg[`B_TX9_EN];

   // character length in link clocks
   function automatic logic [3:0] charLen(input logic ninth);
      charLen = ninth ? `LEN_WIDE : `LEN_NARROW;
   endfunction : charLen

   // direction: either receive enable selects receive
   always_comb
   begin
      if (!portEn || !txCtl_reg[`B_SYNC])
         linkMode = MODE_OFF;
      else if (srenBit || crenBit)
         linkMode = MODE_RX;
      else if (txCtl_reg[`B_TRANSMIT_ENABLE])
         linkMode = MODE_TX;
      else
         linkMode = MODE_OFF;
   end

   // ----------------------------------------
   // apb decode
   // ----------------------------------------
   logic setupPh; // first cycle of a transfer
   logic accessDone; // transfer completes now
   logic wrEn; // write completes now
   logic rdDataPop; // data register read completes

   assign setupPh = psel & ~penable;
   assign accessDone = psel & penable;
   assign wrEn = accessDone & pwrite;
   assign rdDataPop = accessDone & ~pwrite & (paddr == `OFS_RX_DATA);
   assign pready = 1'b1; // no wait states
   assign prdata = prdata_reg;
   assign pslverr = pslverr_reg & accessDone;

   // true for a mapped offset
   function automatic logic isMapped(input logic [7:0] a);
      case (a)
         `OFS_RX_STAT, `OFS_RX_DATA, `OFS_TX_STAT, `OFS_BAUD_CTL,
         `OFS_DIV_HI, `OFS_DIV_LO, `OFS_TX_DATA, `OFS_IRQ_FLAGS,
         `OFS_IRQ_EN, `OFS_IRQ_PRIO, `OFS_CORE_CTL: isMapped = 1'b1;
         default: isMapped = 1'b0;
      endcase
   endfunction : isMapped

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic clkS1; // first stage, read only by clkS2
   logic clkS2; // clean link clock
   logic clkS3; // history for edge detection
   logic datS1; // first stage, read only by datS2
   logic datS2; // clean data level

   // two stages before anything reads the pins
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         clkS1 <= 1'b0;
         clkS2 <= 1'b0;
         clkS3 <= 1'b0;
         datS1 <= 1'b0;
         datS2 <= 1'b0;
      end
      else
      begin
         clkS1 <= clkPinIn;
         clkS2 <= clkS1;
         clkS3 <= clkS2;
         datS1 <= dataIn;
         datS2 <= datS1;
      end
   end

   // ----------------------------------------
   // master clock divider
   // ----------------------------------------
   logic [15:0] divisor; // active divisor
   logic [15:0] divCnt_reg; // cycles in this half period
   logic clkGen_reg; // generated link clock
   logic tick; // half period elapsed
   logic genActive; // master clock may run
   logic rxRun; // receiver shifting
   logic tsrBusy_reg; // shift register holds a character
   logic leadPulse; // leading (rising) link edge
   logic trailPulse; // trailing (falling) link edge

   assign divisor = baudCtl_reg[`B_WIDE_DIV] ? {divHi_reg, divLo_reg}
                                            : {8'h00, divLo_reg};
   assign tick = (divCnt_reg == divisor);
   assign rxRun = (linkMode == MODE_RX) & ~overrun_reg;
   // receive enables alone start the clocks
   assign genActive = masterSel &
      (rxRun | ((linkMode == MODE_TX) & tsrBusy_reg));
   // slave edges come from the synchronised pin
   assign leadPulse = masterSel ? (genActive & tick & ~clkGen_reg)
                                : (clkS2 & ~clkS3);
   assign trailPulse = masterSel ? (genActive & tick & clkGen_reg)
                                 : (~clkS2 & clkS3);

   // half period counter; idles low while genActive is clear
   always_ff @(posedge clk_sys)
   begin
      if (unitRst || !genActive)
      begin
         divCnt_reg <= 16'h0000;
         clkGen_reg <= 1'b0; // stops at once when cut off
      end
      else if (tick)
      begin
         divCnt_reg <= 16'h0000;
         clkGen_reg <= ~clkGen_reg;
      end
      else
         divCnt_reg <= divCnt_reg + 16'h0001;
   end

   // ----------------------------------------
   // receive shifter
   // ----------------------------------------
   logic [3:0] rxCnt_reg; // bits taken so far
   char_t rsr_reg; // partial character
   char_t rxWord; // character as completed
   logic rxDone; // full character this cycle

   assign rxDone = rxRun & trailPulse &
      (rxCnt_reg == charLen(rx9En) - 4'h1);

   // merge the final bit; narrow characters read zero on top
   always_comb
   begin
      rxWord = rsr_reg;
      rxWord[rxCnt_reg] = datS2;
      if (!rx9En)
         rxWord[8] = 1'b0;
   end

   // sample on trailing edge, lsb first
   always_ff @(posedge clk_sys)
   begin
      if (unitRst || !rxRun)
         rxCnt_reg <= 4'h0; // partial character discarded
      else if (trailPulse)
      begin
         rsr_reg[rxCnt_reg] <= datS2;
         if (rxDone)
            rxCnt_reg <= 4'h0;
         else
            rxCnt_reg <= rxCnt_reg + 4'h1;
      end
   end

   // ----------------------------------------
   // two-entry receive buffer
   // ----------------------------------------
   char_t fifoMem [0:1]; // stored characters
   logic rdPtr_reg; // oldest entry
   logic [1:0] fifoCnt_reg; // entries held
   logic wrPtr; // next free entry
   logic push; // store a character
   logic pop; // software consumed one

   assign wrPtr = rdPtr_reg ^ fifoCnt_reg[0];
   assign push = rxDone & (fifoCnt_reg != 2'h2);
   assign pop = rdDataPop & (fifoCnt_reg != 2'h0);

   // storage never overwritten while full
   always_ff @(posedge clk_sys)
   begin
      if (push)
         fifoMem[wrPtr] <= rxWord;
   end

   // occupancy and read pointer
   always_ff @(posedge clk_sys)
   begin
      if (unitRst)
      begin
         rdPtr_reg <= 1'b0;
         fifoCnt_reg <= 2'h0;
      end
      else
      begin
         if (pop)
            rdPtr_reg <= ~rdPtr_reg;
         case ({push, pop})
            2'b10: fifoCnt_reg <= fifoCnt_reg + 2'h1;
            2'b01: fifoCnt_reg <= fifoCnt_reg - 2'h1;
            default: fifoCnt_reg <= fifoCnt_reg;
         endcase
      end
   end

   // overrun: third full character with buffer full
   always_ff @(posedge clk_sys)
   begin
      if (unitRst)
         overrun_reg <= 1'b0;
      else if (rxDone && fifoCnt_reg == 2'h2)
         overrun_reg <= 1'b1;
      else if (!crenBit && (!srenBit || pop))
         overrun_reg <= 1'b0;
   end

   // ----------------------------------------
   // transmit path
   // ----------------------------------------
   logic [7:0] txHold_reg; // waiting character
   logic txFull_reg; // waiting character present
   char_t tsr_reg; // character being shifted
   logic [3:0] txCnt_reg; // bits driven so far
   logic dataOut_reg; // driven data level
   logic txLoad; // move held character to shifter
   logic wrTx; // software wrote a character

   assign wrTx = wrEn & (paddr == `OFS_TX_DATA);
   assign txLoad = txFull_reg & ~tsrBusy_reg &
      (linkMode == MODE_TX);

   // a new write wins over a same-cycle transfer out
   always_ff @(posedge clk_sys)
   begin
      if (unitRst)
         txFull_reg <= 1'b0;
      else if (wrTx)
      begin
         txFull_reg <= 1'b1;
         txHold_reg <= pwdata[7:0];
      end
      else if (txLoad)
         txFull_reg <= 1'b0;
   end

   // shift out: drive on leading edge, finish after trailing
   always_ff @(posedge clk_sys)
   begin
      if (unitRst || linkMode != MODE_TX)
      begin
         tsrBusy_reg <= 1'b0;
         txCnt_reg <= 4'h0;
         dataOut_reg <= 1'b0;
      end
      else if (txLoad)
      begin
         tsr_reg <= {txCtl_reg[`B_TX9_VAL], txHold_reg};
         tsrBusy_reg <= 1'b1;
         txCnt_reg <= 4'h0;
      end
      else if (tsrBusy_reg && leadPulse)
      begin
         dataOut_reg <= tsr_reg[txCnt_reg];
         txCnt_reg <= txCnt_reg + 4'h1;
      end
      else if (tsrBusy_reg && trailPulse &&
               txCnt_reg == charLen(tx9En))
         tsrBusy_reg <= 1'b0;
   end

   assign dataOut = dataOut_reg;
   assign dataOe = (linkMode == MODE_TX);
   assign clkPinOut = clkGen_reg;
   assign clkPinOe = portEn & txCtl_reg[`B_SYNC] & masterSel;

   // ----------------------------------------
   // flags and wake
   // ----------------------------------------
   logic rxFlag; // unread character present
   logic txFlag; // transmit register free
   logic wakeNext; // enabled flag pending

   assign rxFlag = (fifoCnt_reg != 2'h0);
   assign txFlag = ~txFull_reg;
   assign wakeNext = coreCtl_reg[`B_PERIPHERAL_IRQ_ENABLE] &
      ((rxFlag & irqEn_reg[`B_RXF]) |
       (txFlag & irqEn_reg[`B_TXF]));

   // requests run regardless of the core sleeping
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         wakeReq_reg <= 1'b0;
         irqVector_reg <= 1'b0;
      end
      else
      begin
         wakeReq_reg <= wakeNext;
         irqVector_reg <= wakeNext & coreCtl_reg[`B_GIE];
      end
   end

   assign wakeReq = wakeReq_reg;
   assign irqVector = irqVector_reg;

   // ----------------------------------------
   // register writes
   // ----------------------------------------
   // single receive clears after one master character
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         rxCtl_reg <= `RST_BYTE;
      else if (wrEn && paddr == `OFS_RX_STAT)
         rxCtl_reg <= {pwdata[7:4], 4'h0};
      else if (rxDone && masterSel)
         rxCtl_reg[`B_SINGLE_RECEIVE_ENABLE] <= 1'b0;
   end

   // plain read-write control registers
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         txCtl_reg <= `RST_BYTE;
         baudCtl_reg <= `RST_BYTE;
         divHi_reg <= `RST_BYTE;
         divLo_reg <= `RST_BYTE;
         irqEn_reg <= `RST_BYTE;
         irqPrio_reg <= `RST_BYTE;
         coreCtl_reg <= `RST_BYTE;
      end
      else if (wrEn)
      begin
         case (paddr)
            `OFS_TX_STAT: txCtl_reg <= {pwdata[7:4], 3'h0, pwdata[0]};
            `OFS_BAUD_CTL: baudCtl_reg <= pwdata[7:0];
            `OFS_DIV_HI: divHi_reg <= pwdata[7:0];
            `OFS_DIV_LO: divLo_reg <= pwdata[7:0];
            `OFS_IRQ_EN: irqEn_reg <= pwdata[7:0] & 8'h30;
            `OFS_IRQ_PRIO: irqPrio_reg <= pwdata[7:0] & 8'h30;
            `OFS_CORE_CTL: coreCtl_reg <= pwdata[7:0] & 8'hC0;
            default: ;
         endcase
      end
   end

   // ----------------------------------------
   // register reads
   // ----------------------------------------
   logic [7:0] rdByte; // selected register
   char_t topChar; // oldest buffered character

   assign topChar = rxFlag ? fifoMem[rdPtr_reg] : 9'h000;

   // read mux; write-only data reads zero
   always_comb
   begin
      rdByte = 8'h00;
      case (paddr)
         `OFS_RX_STAT: rdByte = {rxCtl_reg[7:4], 2'b00,
                                 overrun_reg, topChar[8]};
         `OFS_RX_DATA: rdByte = topChar[7:0];
         `OFS_TX_STAT: rdByte = {txCtl_reg[7:2], ~tsrBusy_reg,
                                 txCtl_reg[0]};
         `OFS_BAUD_CTL: rdByte = baudCtl_reg;
         `OFS_DIV_HI: rdByte = divHi_reg;
         `OFS_DIV_LO: rdByte = divLo_reg;
         `OFS_IRQ_FLAGS: rdByte = {2'b00, rxFlag, txFlag, 4'h0};
         `OFS_IRQ_EN: rdByte = irqEn_reg;
         `OFS_IRQ_PRIO: rdByte = irqPrio_reg;
         `OFS_CORE_CTL: rdByte = coreCtl_reg;
         default: rdByte = 8'h00;
      endcase
   end

   // answer captured in the setup cycle
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         prdata_reg <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end
      else if (setupPh)
      begin
         prdata_reg <= {24'h000000, rdByte};
         pslverr_reg <= ~isMapped(paddr);
      end
   end

endmodule : sync_serial_port

// >>> testbench/sync_serial_checker.sv
// port-level assertion checker for the synchronous serial port
`timescale 1ns/100ps
module sync_serial_checker
(
   input wire logic clk_sys, // system clock
   input wire logic rst, // reset, high
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb write
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   input wire logic [31:0] prdata, // apb read data
   input wire logic pready, // apb ready
   input wire logic pslverr, // apb error
   input wire logic dataIn, // data pin level
   input wire logic dataOut, // data pin drive value
   input wire logic dataOe, // data pin drive enable
   input wire logic clkPinIn, // link clock pin level
   input wire logic clkPinOut, // generated link clock
   input wire logic clkPinOe, // link clock drive enable
   input wire logic wakeReq, // wake request
   input wire logic irqVector // vectored interrupt
);
   // ------------------------
   // clocking and disable
   // ------------------------
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   // ------------------------
   // bus and reset
   // ------------------------
   a_ready_access: assert property (psel && penable |-> pready) // CONTRACT
      else $error("pready low in access cycle");
   a_err_in_access: assert property (pslverr |-> psel && penable // CONTRACT
      && prdata == 32'h0000_0000) else $error("pslverr outside access");
   a_reset_quiet: assert property (disable iff (1'b0) rst |=> // RESET
      !dataOe && !clkPinOe && !clkPinOut && !wakeReq && !irqVector)
      else $error("outputs active after reset");
   // vector is the wake gated by the global enable
   a_vector_wake: assert property (irqVector |-> wakeReq)
      else $error("vector without wake request");
   // ------------------------
   // link clock, bench divisor gives six cycles per half
   // ------------------------
   a_clk_high_len: assert property ($rose(clkPinOut) |->
      clkPinOut [*6] ##1 !clkPinOut) else $error("bad high phase");
   a_clk_low_len: assert property ($fell(clkPinOut) |->
      !clkPinOut [*6]) else $error("low phase too short");
   a_clk_master: assert property ($rose(clkPinOut) |->
      clkPinOe && !dataOe) else $error("clock made outside master rx");
   // slave data moves only after a rising pin edge
   a_slave_edge: assert property ($changed(dataOut) && dataOe
      && $past(dataOe) && !clkPinOe |-> clkPinIn || $past(clkPinIn))
      else $error("slave data moved off the leading edge");
endmodule : sync_serial_checker
bind sync_serial_port sync_serial_checker chk_u (.clk_sys, .rst, .psel,
   .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .dataIn,
   .dataOut, .dataOe, .clkPinIn, .clkPinOut, .clkPinOe, .wakeReq, .irqVector);

// >>> testbench/sync_serial_peer.sv
// behavioural far-side peer: slave clock source or master-fed sender
`timescale 1ns/100ps
module sync_serial_peer
(
   input wire logic start, // rising edge begins one character
   input wire logic slaveMode, // peer makes the link clock
   input wire logic [3:0] nBits, // bits in the character
   input wire logic [8:0] txChar, // character the peer sends
   input wire logic devClk, // clock made by the device
   input wire logic lineIn, // resolved data line
   output logic linkClk, // clock made by the peer
   output logic peerData, // data the peer drives
   output logic [8:0] rxChar, // character the peer sampled
   output logic busy // frame in progress
);
   initial
   begin
      linkClk = 1'b0;
      peerData = 1'b0;
      rxChar = 9'h000;
      busy = 1'b0;
   end
   // one character per start; the clock stands low between frames
   always
   begin
      @(posedge start);
      busy = 1'b1;
      rxChar = 9'h000;
      for (int i = 0; i < nBits; i++)
      begin
         if (slaveMode)
         begin
            #13 linkClk = 1'b1; // leading edge, data changes
            peerData = txChar[i]; // lsb first
            #32 linkClk = 1'b0; // trailing edge, sample
            rxChar[i] = lineIn;
            #19;
         end
         else
         begin
            @(posedge devClk); // only as many bits as clocks
            #1 peerData = txChar[i];
            @(negedge devClk);
         end
      end
      // released line shows no stale value
      peerData = ~peerData;
      busy = 1'b0;
   end
endmodule : sync_serial_peer

// >>> testbench/tb.sv
// self-checking bench for the synchronous serial port
`timescale 1ns/100ps
`include "sync_serial_defs.svh"
module tb;
   import sync_serial_pkg::*;
   // ------------------------
   // signals
   // ------------------------
   typedef struct packed {logic [7:0] addr; logic [7:0] val;} row_s;
   logic clk_sys = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, peerStart = 1'b0, peerSlave = 1'b1;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic pready, pslverr, dataOut, dataOe, clkPinOut, clkPinOe, wakeReq;
   logic irqVector, linkClk, peerData, peerBusy, er;
   logic [3:0] peerBits = 4'h8;
   logic [8:0] peerTx = 9'h000, peerRx;
   int err_total = 0, compares = 0, clkRises = 0;
   wire dataLine = dataOe ? dataOut : peerData; // resolved data pin
   wire clkLine = clkPinOe ? clkPinOut : linkClk; // resolved clock pin
   row_s rows [6] = '{'{`OFS_DIV_HI, 8'hA5}, '{`OFS_DIV_LO, 8'h5A},
      '{`OFS_IRQ_PRIO, 8'h30}, '{`OFS_IRQ_EN, 8'h30},
      '{`OFS_BAUD_CTL, 8'h08}, '{`OFS_CORE_CTL, 8'hC0}};
   always #4 clk_sys = ~clk_sys; // 125 MHz
   always @(posedge clkPinOut) clkRises++; // generated clock count
   // ------------------------
   // instances
   // ------------------------
   sync_serial_port dut_u (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .dataIn(dataLine), .dataOut,
      .dataOe, .clkPinIn(clkLine), .clkPinOut, .clkPinOe, .wakeReq,
      .irqVector);
   sync_serial_peer peer_u (.start(peerStart), .slaveMode(peerSlave),
      .nBits(peerBits), .txChar(peerTx), .devClk(clkPinOut),
      .lineIn(dataLine), .linkClk, .peerData,
      .rxChar(peerRx), .busy(peerBusy));
   // ------------------------
   // tasks
   // ------------------------
   task check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         err_total++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : check
   // access phase held until pready is seen high
   task apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h00_0000, d};
      @(posedge clk_sys);
      penable <= 1'b1;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      rd = prdata;
      er = pslverr;
      if (n >= 50)
         check(32'h0000_0000, 32'h0000_0001);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task rdCheck(input logic [7:0] a, input logic [7:0] exp);
      apb(1'b0, a, 8'h00);
      check({24'h00_0000, rd[7:0]}, {24'h00_0000, exp});
   endtask : rdCheck
   task waitPeer;
      for (int n = 0; n < 5000 && peerBusy !== 1'b0; n++)
         @(posedge clk_sys);
      check({31'h0, peerBusy}, 32'h0000_0000); // frame finished
   endtask : waitPeer
   task frame(input logic sl, input logic [3:0] n, input logic [8:0] c);
      @(posedge clk_sys);
      peerSlave <= sl;
      peerBits <= n;
      peerTx <= c;
      peerStart <= 1'b1;
      @(posedge clk_sys);
      peerStart <= 1'b0;
      if (sl)
         waitPeer();
   endtask : frame
   task give_verdict;
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : give_verdict
   // ------------------------
   // watchdog, far past the expected run
   // ------------------------
   initial
   begin
      #400000;
      err_total++;
      give_verdict();
   end
   // ------------------------
   // main sequence
   // ------------------------
   initial
   begin
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      rdCheck(`OFS_RX_STAT, `RST_BYTE); // RESET
      foreach (rows[i]) // plain read-write registers
      begin
         rdCheck(rows[i].addr, `RST_BYTE); // RESET
         apb(1'b1, rows[i].addr, rows[i].val);
         rdCheck(rows[i].addr, rows[i].val); // CONTRACT
      end
      apb(1'b0, 8'h30, 8'h00);
      check({16'h0, rd[7:0], 7'h00, er}, 32'h0000_0001); // CONTRACT
      $display("test registers done");
      // slave transmit, two characters queued back to back
      apb(1'b1, `OFS_DIV_HI, 8'h00);
      apb(1'b1, `OFS_BAUD_CTL, 8'h00);
      apb(1'b1, `OFS_TX_STAT, 8'h30);
      apb(1'b1, `OFS_RX_STAT, 8'h80);
      apb(1'b1, `OFS_IRQ_EN, 8'h10);
      apb(1'b1, `OFS_TX_DATA, 8'hA5);
      apb(1'b1, `OFS_TX_DATA, 8'h3C);
      rdCheck(`OFS_IRQ_FLAGS, 8'h00);
      check({30'h0, wakeReq, dataOe}, 32'h0000_0001);
      frame(1'b1, 4'h8, 9'h1FF);
      check({23'h0, peerRx}, 32'h0000_00A5);
      repeat (8) @(posedge clk_sys);
      rdCheck(`OFS_IRQ_FLAGS, 8'h10);
      check({30'h0, wakeReq, irqVector}, 32'h0000_0003);
      frame(1'b1, 4'h8, 9'h000);
      check({23'h0, peerRx}, 32'h0000_003C);
      apb(1'b1, `OFS_CORE_CTL, 8'h40);
      repeat (3) @(posedge clk_sys);
      check({30'h0, wakeReq, irqVector}, 32'h0000_0002);
      $display("test slave transmit done");
      // slave receive with only the single enable set
      apb(1'b1, `OFS_RX_STAT, 8'h00);
      apb(1'b1, `OFS_TX_STAT, 8'h10);
      apb(1'b1, `OFS_IRQ_EN, 8'h20);
      apb(1'b1, `OFS_CORE_CTL, 8'hC0);
      apb(1'b1, `OFS_RX_STAT, 8'hA0);
      frame(1'b1, 4'h8, 9'h096);
      frame(1'b1, 4'h8, 9'h04B); // receiver kept going
      repeat (8) @(posedge clk_sys);
      check({30'h0, wakeReq, irqVector}, 32'h0000_0003);
      rdCheck(`OFS_IRQ_FLAGS, 8'h30);
      rdCheck(`OFS_RX_DATA, 8'h96);
      rdCheck(`OFS_RX_DATA, 8'h4B);
      rdCheck(`OFS_IRQ_FLAGS, 8'h10);
      $display("test slave receive done");
      // nine-bit characters, the third overruns
      apb(1'b1, `OFS_RX_STAT, 8'h00);
      apb(1'b1, `OFS_RX_STAT, 8'hD0);
      frame(1'b1, 4'h9, 9'h1A5);
      frame(1'b1, 4'h9, 9'h05A);
      frame(1'b1, 4'h9, 9'h1FF);
      repeat (8) @(posedge clk_sys);
      rdCheck(`OFS_RX_STAT, 8'hD3);
      rdCheck(`OFS_RX_DATA, 8'hA5);
      rdCheck(`OFS_RX_STAT, 8'hD2);
      rdCheck(`OFS_RX_DATA, 8'h5A);
      apb(1'b1, `OFS_RX_STAT, 8'hC0);
      rdCheck(`OFS_RX_STAT, 8'hC0);
      $display("test overrun done");
      // port disabled, a frame leaves no trace
      apb(1'b1, `OFS_RX_STAT, 8'h10);
      frame(1'b1, 4'h8, 9'h077);
      repeat (8) @(posedge clk_sys);
      check({31'h0, wakeReq}, 32'h0000_0000);
      $display("test port disabled done");
      // master single receive, half period is divisor plus one
      apb(1'b1, `OFS_DIV_LO, 8'h05);
      apb(1'b1, `OFS_TX_STAT, 8'h90);
      apb(1'b1, `OFS_RX_STAT, 8'h80);
      clkRises = 0;
      frame(1'b0, 4'h8, 9'h0C3);
      apb(1'b1, `OFS_RX_STAT, 8'hA0);
      waitPeer();
      repeat (20) @(posedge clk_sys);
      check(clkRises, 32'h0000_0008);
      check({31'h0, clkPinOe}, 32'h0000_0001);
      rdCheck(`OFS_RX_STAT, 8'h80);
      rdCheck(`OFS_RX_DATA, 8'hC3);
      $display("test master receive done");
      // second reset in mid-run
      @(posedge clk_sys);
      rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      check({29'h0, clkPinOe, dataOe, wakeReq}, 32'h0000_0000); // RESET
      rdCheck(`OFS_TX_STAT, 8'h02); // RESET
      $display("test second reset done");
      give_verdict();
   end
endmodule : tb
